/* File: ftc_adc_model.sv */
// behavioural adc sample stream feeding the capture block
`timescale 1ns/1ps
module ftc_adc_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // code to present on each sample
  input  wire logic [15:0] level_i,
  // sample stream
  output logic             stb_o,
  output logic      [15:0] data_o
);
  logic [2:0] cnt_q;  // clocks since last sample
  logic [2:0] cnt_d;  // next count

  // five clocks of 4 ns make one sample period
  always_comb begin
    cnt_d = (cnt_q == 3'h4) ? 3'h0 : cnt_q + 3'h1;
  end

  // count register
  always_ff @(posedge clk_i) begin
    cnt_q <= rst_i ? 3'h0 : cnt_d;
  end

  assign stb_o  = (cnt_q == 3'h4);
  // outside a sample the code is not held, so show its inverse
  assign data_o = stb_o ? level_i : ~level_i;
endmodule

/* File: ftc_baseline.sv */
// baseline acceptance gate and running average
`timescale 1ns/1ps
module ftc_baseline
  import ftc_pkg::*;
#(
  parameter int SUM_W = 32
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // filter taps
  input  wire logic               stb_i,
  input  wire logic signed [15:0] fast_i,
  input  wire logic signed [15:0] bfilt_i,
  // settings
  input  wire logic signed [15:0] tthr_i,
  input  wire logic signed [15:0] bthr_i,
  input  wire logic        [3:0]  blen_i,
  // results
  output logic signed      [15:0] avg_o,
  output logic signed      [15:0] samp_o,
  output logic                    acc_o
);
  if (SUM_W < 16 + 12) begin : g_chk
    $error("sum too narrow for the longest average");
  end
  logic signed [SUM_W-1:0] sum_q, sum_d;    // average times length
  logic signed [15:0]      avg_q, avg_d;    // running average
  logic signed [15:0]      samp_q, samp_d;  // last accepted sample
  logic                    acc_q, acc_d;    // sample accepted

  ////////////////////////////////////////////////////////////////////
  // next values: accept only quiet samples, then average them
  always_comb begin
    acc_d  = stb_i && (fast_i < tthr_i) && (bfilt_i < bthr_i);
    sum_d  = sum_q;
    samp_d = samp_q;
    if (acc_d) begin
      sum_d  = sum_q + SUM_W'(bfilt_i) - (sum_q >>> blen_i);
      samp_d = bfilt_i;
    end
    avg_d  = 16'(sum_d >>> blen_i);
  end

  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sum_q  <= '0;
      avg_q  <= '0;
      samp_q <= '0;
      acc_q  <= 1'b0;
    end else begin
      sum_q  <= sum_d;
      avg_q  <= avg_d;
      samp_q <= samp_d;
      acc_q  <= acc_d;
    end
  end
  assign avg_o  = avg_q;
  assign samp_o = samp_q;
  assign acc_o  = acc_q;

  ////////////////////////////////////////////////////////////////////
  base_gate_a : assert property (@(posedge clk_i) disable iff (rst_i)
    acc_q |-> $past(stb_i) && $past(fast_i < tthr_i) && $past(bfilt_i < bthr_i))
    else $error("baseline sample accepted above a threshold");
endmodule

/* File: ftc_cap_if.sv */
// carrier between the capture control and the trace buffer
`timescale 1ns/1ps
interface ftc_cap_if;
  logic              start;    // begin a trace
  logic [15:0]       point;    // point to store
  logic              pt_stb;   // point is new
  logic [15:0]       intv;     // interval minus one
  logic              busy;     // trace in progress
  logic              done;     // trace complete and held
  logic [11:0]       rd_addr;  // buffer read index
  logic [15:0]       rd_data;  // buffer read word
  modport ctl (output start, point, pt_stb, intv, rd_addr, input busy, done, rd_data);
  modport cap (input start, point, pt_stb, intv, rd_addr, output busy, done, rd_data);
endinterface

/* File: ftc_capture.sv */
// trace buffer with interval counter and capture sequencer
`timescale 1ns/1ps
module ftc_capture
  import ftc_pkg::*;
#(
  parameter int DEPTH = TRACE_LEN
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // control side
  ftc_cap_if.cap    cif
);
  localparam int PW = $clog2(DEPTH);
  if (DEPTH < 2 || DEPTH > TRACE_LEN || DEPTH != (1 << PW)) begin : g_chk
    $error("depth must be a power of two up to the trace length");
  end
  ftc_cap_st_t      st_q, st_d;    // sequencer state
  logic [PW-1:0]    ptr_q, ptr_d;  // next point index
  logic [15:0]      cnt_q, cnt_d;  // strobes left before next point
  logic             we;            // store this point
  logic [PT_W-1:0]  mem_q [DEPTH]; // trace storage
  logic [PT_W-1:0]  rd_q;          // registered read word

  ////////////////////////////////////////////////////////////////////
  // sequencer: one point every intv+1 strobes until full
  always_comb begin
    st_d  = st_q;
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    we    = 1'b0;
    unique case (st_q)
      CAP_IDLE, CAP_DONE: begin
        // a request restarts; a finished trace is held till then
        if (cif.start) begin
          st_d  = CAP_RUN;
          ptr_d = '0;
          cnt_d = '0;
        end
      end
      CAP_RUN: begin
        if (cif.pt_stb) begin
          if (cnt_q == '0) begin
            we    = 1'b1;
            cnt_d = cif.intv;
            ptr_d = ptr_q + 1'b1;
            if (ptr_q == PW'(DEPTH - 1)) begin
              st_d = CAP_DONE;
            end
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
      end
    endcase
  end

  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q  <= CAP_IDLE;
      ptr_q <= '0;
      cnt_q <= '0;
    end else begin
      st_q  <= st_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
    end
  end

  // storage write and registered read
  always_ff @(posedge clk_i) begin
    if (we) begin
      mem_q[ptr_q] <= cif.point;
    end
    rd_q <= mem_q[cif.rd_addr[PW-1:0]];
  end
  assign cif.rd_data = rd_q;
  assign cif.busy    = (st_q == CAP_RUN);
  assign cif.done    = (st_q == CAP_DONE);

  ////////////////////////////////////////////////////////////////////
  full_done_a : assert property (@(posedge clk_i) disable iff (rst_i)
    we && ptr_q == PW'(DEPTH - 1) |=> st_q == CAP_DONE && ptr_q == '0)
    else $error("trace did not end after the last point");
  point_space_a : assert property (@(posedge clk_i) disable iff (rst_i)
    we |-> cnt_q == '0 ##1 cnt_q == $past(cif.intv))
    else $error("point interval counter misloaded");
  start_run_a : assert property (@(posedge clk_i) disable iff (rst_i)
    cif.start && st_q != CAP_RUN |=> st_q == CAP_RUN && ptr_q == '0)
    else $error("capture request not taken");
endmodule

/* File: ftc_pkg.sv */
// shared constants, types and register map of the filter trace capture block
package ftc_pkg;
  // trace geometry
  localparam int          TRACE_LEN     = 4096;         // points per trace
  localparam int          PT_W          = 16;           // bits per point
  localparam int          ADDR_W        = 12;           // point index width
  localparam logic [15:0] MID_SCALE     = 16'h8000;     // zero of a signed tap
  // capture interval, counted in adc sample periods
  localparam int          SAMPLE_NS     = 20;           // adc sample period
  localparam int          INT_MIN_NS    = 20;           // shortest interval
  localparam int          INT_MAX_US    = 1000;         // longest interval
  localparam int          INT_MIN_TICKS = INT_MIN_NS / SAMPLE_NS;
  localparam int          INT_MAX_TICKS = (INT_MAX_US * 1000) / SAMPLE_NS;
  localparam logic [15:0] INTV_MAX      = 16'(INT_MAX_TICKS - 1);
  // register byte offsets
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_INTV      = 8'h04;
  localparam logic [7:0]  REG_STAT      = 8'h08;
  localparam logic [7:0]  REG_TTHR      = 8'h0c;
  localparam logic [7:0]  REG_BTHR      = 8'h10;
  localparam logic [7:0]  REG_BLEN      = 8'h14;
  localparam logic [7:0]  REG_DECIM     = 8'h18;
  localparam int          BUF_SEL_BIT   = 14;           // address bit of the buffer window
  // field positions
  localparam int          CTRL_START    = 0;
  localparam int          CTRL_POL      = 1;
  localparam int          CTRL_SRC_LSB  = 4;
  localparam int          STAT_BUSY     = 0;
  localparam int          STAT_DONE     = 1;
  // reset values
  localparam logic [15:0] INTV_RST      = 16'h0000;
  localparam logic [15:0] TTHR_RST      = 16'h7fff;
  localparam logic [15:0] BTHR_RST      = 16'h7fff;
  localparam logic [3:0]  BLEN_RST      = 4'h8;         // 256 samples
  localparam logic [3:0]  BLEN_MIN      = 4'h4;         // 16 samples
  localparam logic [3:0]  BLEN_MAX      = 4'hc;         // 4096 samples
  // waveform sources
  typedef enum logic [2:0] {
    SRC_ADC   = 3'h0, SRC_BHIST = 3'h1, SRC_TRIG  = 3'h2, SRC_BFILT = 3'h3,
    SRC_EFILT = 3'h4, SRC_BSAMP = 3'h5, SRC_ESAMP = 3'h6
  } ftc_src_t;
  // capture states
  typedef enum logic [2:0] {
    CAP_IDLE = 3'b001, CAP_RUN = 3'b010, CAP_DONE = 3'b100
  } ftc_cap_st_t;
endpackage

/* File: ftc_top.sv */
// filter trace capture: tap selection, offset, wishbone registers
//
// Overview of operation
// - trace is 4096 sixteen-bit points
// - signed taps stored offset by 32768
// - interval programmable 0.020 to 1000 us
// - shortest interval stores every adc sample
// - polarity bit inverts adc before filters
// - adc source is post-inversion, unsigned
// - source: signed baseline running average
// - source: signed fast trigger filter
// - source: baseline filter, energy at decimation 0
// - source: signed slow energy filter
// - source: accepted baseline samples only
// - source: unsigned chosen energy peak samples
// - baseline average length is programmable
// - accept baseline only below both thresholds
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ps
module ftc_top
  import ftc_pkg::*;
#(
  parameter int DEPTH = TRACE_LEN
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // adc stream and filter taps
  input  wire logic        adc_stb_i,
  input  wire logic [15:0] adc_data_i,
  input  wire logic [15:0] fast_filt_i,
  input  wire logic [15:0] base_filt_i,
  input  wire logic [15:0] energy_filt_i,
  input  wire logic        peak_vld_i,
  input  wire logic [15:0] peak_data_i,
  // to the filter pipeline
  output logic      [15:0] adc_pipe_o,
  output logic             adc_pipe_stb_o,
  output logic      [15:0] base_avg_o,
  // status
  output logic             trace_done_o
);
  // a shorter trace aliases in the buffer window; a longer one does not fit it
  if (DEPTH < 2 || DEPTH > TRACE_LEN) begin : g_chk
    $error("trace depth must fit the buffer window");
  end

  ////////////////////////////////////////////////////////////////////
  // declarations
  ftc_cap_if cif ();                       // link to the buffer
  logic        ack_q, ack_d;               // bus answer
  logic        pend_q, pend_d;             // request taken, answer next
  logic [31:0] dat_q, dat_d;               // read data
  logic        pol_q, pol_d;               // invert adc
  ftc_src_t    src_q, src_d;               // waveform source
  logic [15:0] intv_q, intv_d;             // interval minus one
  logic [15:0] tthr_q, tthr_d;             // trigger threshold
  logic [15:0] bthr_q, bthr_d;             // baseline threshold
  logic [3:0]  blen_q, blen_d;             // log2 average length
  logic [3:0]  dec_q, dec_d;               // decimation setting
  logic        start_q, start_d;           // capture request pulse
  logic [15:0] pipe_q, pipe_d;             // adc after polarity
  logic        pstb_q, pstb_d;             // adc sample valid
  logic [15:0] pt_q, pt_d;                 // selected point
  logic        ptstb_q, ptstb_d;           // point valid
  logic        done_q, done_d;             // trace finished
  logic [15:0] bf_sel;                     // baseline filter tap
  logic signed [15:0] avg, bsamp;          // baseline results
  logic        bacc;                       // baseline accepted
  logic        wr_hit;                     // register write now
  logic [7:0]  roff;                       // register offset

  ////////////////////////////////////////////////////////////////////
  // byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // move a signed tap to mid-scale
  function automatic logic [15:0] offs(input logic [15:0] v);
    return 16'(v + MID_SCALE);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // baseline gate and running average
  ftc_baseline u_base (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .stb_i   (pstb_q),
    .fast_i  (fast_filt_i),
    .bfilt_i (bf_sel),
    .tthr_i  (tthr_q),
    .bthr_i  (bthr_q),
    .blen_i  (blen_q),
    .avg_o   (avg),
    .samp_o  (bsamp),
    .acc_o   (bacc)
  );

  // trace buffer
  ftc_capture #(.DEPTH(DEPTH)) u_cap (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cif   (cif)
  );

  // at decimation 0 the baseline tap is the energy filter
  assign bf_sel = (dec_q == '0) ? energy_filt_i : base_filt_i;

  ////////////////////////////////////////////////////////////////////
  // wishbone slave: take request, answer two edges later
  always_comb begin
    roff    = wb_adr_i[7:0];
    pend_d  = 1'b0;
    ack_d   = 1'b0;
    dat_d   = dat_q;
    wr_hit  = 1'b0;
    start_d = 1'b0;
    pol_d   = pol_q;
    src_d   = src_q;
    intv_d  = intv_q;
    tthr_d  = tthr_q;
    bthr_d  = bthr_q;
    blen_d  = blen_q;
    dec_d   = dec_q;
    if (wb_cyc_i && wb_stb_i && !ack_q && !pend_q) begin
      // new request: wait one cycle for the buffer read
      pend_d = 1'b1;
    end else if (pend_q) begin
      // answer with data; writes land on this edge
      ack_d  = 1'b1;
      wr_hit = wb_we_i && !wb_adr_i[BUF_SEL_BIT];
      dat_d  = '0;
      if (wb_adr_i[BUF_SEL_BIT]) begin
        // buffer window, read only
        dat_d = {16'h0000, cif.rd_data};
      end else begin
        unique case (roff)
          REG_CTRL:  dat_d = {25'h0, src_q, 2'h0, pol_q, 1'b0};
          REG_INTV:  dat_d = {16'h0, intv_q};
          REG_STAT:  dat_d = {30'h0, done_q, cif.busy};
          REG_TTHR:  dat_d = {16'h0, tthr_q};
          REG_BTHR:  dat_d = {16'h0, bthr_q};
          REG_BLEN:  dat_d = {28'h0, blen_q};
          REG_DECIM: dat_d = {28'h0, dec_q};
          default:   dat_d = '0;
        endcase
      end
    end
    // register writes, through the byte enables
    if (wr_hit) begin
      unique case (roff)
        REG_CTRL: begin
          logic [31:0] c;
          c       = merge({25'h0, src_q, 2'h0, pol_q, 1'b0}, wb_dat_i, wb_sel_i);
          pol_d   = c[CTRL_POL];
          src_d   = (c[CTRL_SRC_LSB +: 3] == 3'h7) ? SRC_ADC : ftc_src_t'(c[CTRL_SRC_LSB +: 3]);
          // a request while a trace runs is ignored
          start_d = c[CTRL_START] && wb_sel_i[0] && !cif.busy;
        end
        REG_INTV: begin
          logic [31:0] c;
          c      = merge({16'h0, intv_q}, wb_dat_i, wb_sel_i);
          // clamp to the longest interval
          intv_d = (c[15:0] > INTV_MAX) ? INTV_MAX : c[15:0];
        end
        REG_TTHR: begin
          logic [31:0] c;
          c      = merge({16'h0, tthr_q}, wb_dat_i, wb_sel_i);
          tthr_d = c[15:0];
        end
        REG_BTHR: begin
          logic [31:0] c;
          c      = merge({16'h0, bthr_q}, wb_dat_i, wb_sel_i);
          bthr_d = c[15:0];
        end
        REG_BLEN: begin
          logic [31:0] c;
          c      = merge({28'h0, blen_q}, wb_dat_i, wb_sel_i);
          // keep the length within the supported range
          blen_d = (c[3:0] < BLEN_MIN) ? BLEN_MIN :
                   (c[3:0] > BLEN_MAX) ? BLEN_MAX : c[3:0];
        end
        REG_DECIM: begin
          logic [31:0] c;
          c     = merge({28'h0, dec_q}, wb_dat_i, wb_sel_i);
          dec_d = c[3:0];
        end
        default: begin
          // unmapped or read-only: write dropped
        end
      endcase
    end
  end

  // bus and settings registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q  <= 1'b0;
      ack_q   <= 1'b0;
      dat_q   <= '0;
      start_q <= 1'b0;
      pol_q   <= 1'b0;
      src_q   <= SRC_ADC;
      intv_q  <= INTV_RST;
      tthr_q  <= TTHR_RST;
      bthr_q  <= BTHR_RST;
      blen_q  <= BLEN_RST;
      dec_q   <= '0;
    end else begin
      pend_q  <= pend_d;
      ack_q   <= ack_d;
      dat_q   <= dat_d;
      start_q <= start_d;
      pol_q   <= pol_d;
      src_q   <= src_d;
      intv_q  <= intv_d;
      tthr_q  <= tthr_d;
      bthr_q  <= bthr_d;
      blen_q  <= blen_d;
      dec_q   <= dec_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // data path: polarity, source select, offset
  always_comb begin
    pipe_d  = pstb_q ? pipe_q : pipe_q;
    pstb_d  = adc_stb_i;
    if (adc_stb_i) begin
      pipe_d = pol_q ? ~adc_data_i : adc_data_i;
    end
    pt_d    = pt_q;
    ptstb_d = 1'b0;
    unique case (src_q)
      SRC_ADC: begin
        ptstb_d = pstb_q;
        pt_d    = pipe_q;
      end
      SRC_BHIST: begin
        ptstb_d = pstb_q;
        pt_d    = offs(avg);
      end
      SRC_TRIG: begin
        ptstb_d = pstb_q;
        pt_d    = offs(fast_filt_i);
      end
      SRC_BFILT: begin
        ptstb_d = pstb_q;
        pt_d    = offs(bf_sel);
      end
      SRC_EFILT: begin
        ptstb_d = pstb_q;
        pt_d    = offs(energy_filt_i);
      end
      SRC_BSAMP: begin
        ptstb_d = bacc;
        pt_d    = offs(bsamp);
      end
      SRC_ESAMP: begin
        ptstb_d = peak_vld_i;
        pt_d    = peak_data_i;
      end
    endcase
    // done follows the buffer, cleared by a new request
    done_d = cif.done;
  end

  // data path registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pipe_q  <= '0;
      pstb_q  <= 1'b0;
      pt_q    <= '0;
      ptstb_q <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      pipe_q  <= pipe_d;
      pstb_q  <= pstb_d;
      pt_q    <= pt_d;
      ptstb_q <= ptstb_d;
      done_q  <= done_d;
    end
  end

  // buffer link
  assign cif.start   = start_q;
  assign cif.point   = pt_q;
  assign cif.pt_stb  = ptstb_q;
  assign cif.intv    = intv_q;
  assign cif.rd_addr = wb_adr_i[13:2];

  // outputs, all from flops
  assign wb_ack_o       = ack_q;
  assign wb_dat_o       = dat_q;
  assign adc_pipe_o     = pipe_q;
  assign adc_pipe_stb_o = pstb_q;
  assign base_avg_o     = avg;
  assign trace_done_o   = done_q;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ack_pulse_a : assert property (ack_q |=> !ack_q)
    else $error("ack held longer than one cycle");
  adc_invert_a : assert property (adc_stb_i && pol_q |=> pipe_q == ~$past(adc_data_i))
    else $error("adc polarity not applied");
  raw_adc_a : assert property (pstb_q && src_q == SRC_ADC |=> ptstb_q && pt_q == $past(pipe_q))
    else $error("adc point not stored unsigned");
  trig_mid_a : assert property (pstb_q && src_q == SRC_TRIG |=>
    pt_q == 16'($past(fast_filt_i) + 16'h8000))
    else $error("trigger point not offset to mid-scale");
  zero_mid_a : assert property (pstb_q && src_q == SRC_EFILT && energy_filt_i == '0 |=> pt_q == 16'h8000)
    else $error("signed zero not stored as 32768");
  energy_pt_a : assert property (pstb_q && src_q == SRC_EFILT |=>
    pt_q == 16'($past(energy_filt_i) + 16'h8000))
    else $error("energy point wrong");
  decim_zero_a : assert property (pstb_q && src_q == SRC_BFILT && dec_q == '0 |=>
    pt_q == 16'($past(energy_filt_i) + 16'h8000))
    else $error("baseline filter not energy at decimation 0");
  bsamp_only_a : assert property (src_q == SRC_BSAMP && $past(src_q) == SRC_BSAMP |-> ptstb_q == $past(bacc))
    else $error("baseline sample source passed a rejected sample");
  esamp_only_a : assert property (src_q == SRC_ESAMP |=> ptstb_q == $past(peak_vld_i))
    else $error("energy sample source passed a non-peak");
  intv_range_a : assert property (intv_q <= INTV_MAX)
    else $error("interval beyond the longest setting");
  every_sample_a : assert property (cif.busy && intv_q == '0 && src_q == SRC_ADC && pstb_q
    |=> ptstb_q)
    else $error("shortest interval skipped an adc sample");
endmodule

/* File: ftc_top_tb.sv */
// self-checking bench of the filter trace capture block
`timescale 1ns/1ps
module ftc_top_tb;
  import ftc_pkg::*;
  localparam int DP = 16;  // short trace keeps the run brief
  // one ordinary case: source, polarity, stimulus, stored word
  typedef struct packed {
    logic [2:0] src; logic pol; logic [15:0] adc, fast, base, en, exp;
  } ftc_row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [15:0] adr = 16'h0, lvl = 16'h0, fast = 16'h0, base = 16'h0, en = 16'h0;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic        ack, astb, done, pstb;
  logic [15:0] adata, pipe, bavg;
  int          mismatches = 0, checks = 0, n;
  ftc_row_t    rows [9];

  always #2 clk_i = ~clk_i;

  ftc_adc_model adc (.clk_i(clk_i), .rst_i(rst_i), .level_i(lvl), .stb_o(astb), .data_o(adata));

  ftc_top #(.DEPTH(DP)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .adc_stb_i(astb),
    .adc_data_i(adata), .fast_filt_i(fast), .base_filt_i(base), .energy_filt_i(en),
    .peak_vld_i(astb), .peak_data_i(16'h4321), .adc_pipe_o(pipe), .adc_pipe_stb_o(pstb),
    .base_avg_o(bavg), .trace_done_o(done));

  ////////////////////////////////////////////////////////////////////////
  // verdict and run end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // compare seen against expected
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    rd = rdat;
    if (k >= 50) begin
      chk("ack", 1'b0, 1'b1);
      end_of_test();
    end
    {cyc, stb} <= 2'b00;
  endtask

  // wait for a held trace, leaving the old flag time to clear
  task automatic wait_done();
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((done !== 1'b1 || n < 4) && n < 9000);
    if (n >= 9000) begin
      chk("done", 1'b0, 1'b1);
      end_of_test();
    end
  endtask

  // program interval and source, start, then check timing and end points
  task automatic cap(input logic [2:0] s, input logic p, input logic [15:0] iv, input logic [15:0] ex);
    int lo;
    lo = (DP - 1) * (iv + 1) * 5;
    // settle source and polarity before the start, so point 0 is not stale
    wb(1'b1, REG_CTRL, {25'h0, s, 2'b00, p, 1'b0});
    wb(1'b1, REG_INTV, {16'h0, iv});
    wb(1'b1, REG_CTRL, {25'h0, s, 2'b00, p, 1'b1});
    wait_done();
    chk("interval", n >= lo && n <= lo + 16, 1'b1);
    for (int i = 0; i < DP; i += DP - 1) begin
      wb(1'b0, 16'h4000 + 16'(4 * i), 32'h0);
      chk("point", rd, {16'h0, ex});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{'{3'h0, 1'b0, 16'h1234, 16'h0, 16'h0, 16'h0, 16'h1234},
             '{3'h0, 1'b1, 16'h1234, 16'h0, 16'h0, 16'h0, 16'hedcb},
             '{3'h1, 1'b0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h8000},
             '{3'h2, 1'b1, 16'h1234, 16'h0010, 16'h0, 16'h0, 16'h8010},
             '{3'h3, 1'b0, 16'h0, 16'h0, 16'h0, 16'h1111, 16'h9111},
             '{3'h4, 1'b0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h8000},
             '{3'h5, 1'b0, 16'h0, 16'h0, 16'h0100, 16'h0100, 16'h8100},
             '{3'h6, 1'b0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h4321},
             '{3'h7, 1'b0, 16'h0abc, 16'h0, 16'h0, 16'h0, 16'h0abc}};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_STAT, 32'h0);
    chk("stat", rd, 32'h0);
    // ordinary cases
    foreach (rows[i]) begin
      @(posedge clk_i);
      {lvl, fast, base, en} <= {rows[i].adc, rows[i].fast, rows[i].base, rows[i].en};
      cap(rows[i].src, rows[i].pol, 16'h0, rows[i].exp);
      chk("pipe", pipe, rows[i].adc ^ {16{rows[i].pol}});
      $display("row %0d done", i);
    end
    // register defaults, clamps and an unmapped place
    wb(1'b0, REG_TTHR, 32'h0);
    chk("tthr", rd, 32'h7fff);
    wb(1'b0, 16'h001c, 32'h0);
    chk("unmapped", rd, 32'h0);
    wb(1'b1, REG_BLEN, 32'h2);
    wb(1'b0, REG_BLEN, 32'h0);
    chk("blen", rd, 32'h4);
    wb(1'b1, REG_INTV, 32'hffff);
    wb(1'b0, REG_INTV, 32'h0);
    chk("intv", rd, 32'hc34f);
    $display("register test done");
    // decimation above zero gives the true baseline filter
    wb(1'b1, REG_DECIM, 32'h1);
    {base, en} <= {16'hfffe, 16'h1111};
    cap(3'h3, 1'b0, 16'h0, 16'h7ffe);
    $display("decimation test done");
    // trigger above threshold blocks baseline samples
    {fast, base, en} <= {16'h0010, 16'h0100, 16'h0100};
    wb(1'b1, REG_TTHR, 32'h5);
    wb(1'b1, REG_CTRL, 32'h51);
    repeat (200) @(posedge clk_i);
    wb(1'b0, REG_STAT, 32'h0);
    chk("blocked", rd, 32'h1);
    fast <= 16'h0;
    wait_done();
    wb(1'b0, 16'h4000, 32'h0);
    chk("sample", rd, 32'h8100);
    repeat (20) @(posedge clk_i);
    chk("held", done, 1'b1);
    wb(1'b0, REG_STAT, 32'h0);
    chk("stat", rd, 32'h2);
    $display("threshold test done");
    // spaced points: one per three samples
    lvl <= 16'h0321;
    cap(3'h0, 1'b0, 16'h2, 16'h0321);
    $display("interval test done");
    // reset in the middle of a trace clears flag, settings and outputs
    wb(1'b1, REG_CTRL, 32'h1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("rst done", done, 1'b0);
    chk("rst pipe", {pstb, pipe}, 32'h0);
    chk("rst avg", bavg, 32'h0);
    rst_i <= 1'b0;
    wb(1'b0, REG_STAT, 32'h0);
    chk("rst stat", rd, 32'h0);
    wb(1'b0, REG_INTV, 32'h0);
    chk("rst intv", rd, 32'h0);
    $display("reset test done");
    end_of_test();
  end
endmodule
